// [logic/aio_regs_pkg.sv]
/*
  register map, field positions, reset values and carriers of the
  board control register bank.
  assumes a single clock domain and a simple synchronous register port.
*/
`default_nettype none
package aio_regs_pkg;

  localparam int unsigned ADDR_W = 6;

  localparam logic [5:0] OFF_BOARD_CONTROL = 6'h00;
  localparam logic [5:0] OFF_INTR_CONTROL  = 6'h04;
  localparam logic [5:0] OFF_INPUT_BUF     = 6'h08;
  localparam logic [5:0] OFF_INPUT_BUF_CTL = 6'h0C;
  localparam logic [5:0] OFF_RATE_A        = 6'h10;
  localparam logic [5:0] OFF_RATE_B        = 6'h14;
  localparam logic [5:0] OFF_OUTPUT_BUF    = 6'h18;
  localparam logic [5:0] OFF_OUTPUT_BUF_CT = 6'h1C;
  localparam logic [5:0] OFF_SCAN_SYNC     = 6'h20;
  localparam logic [5:0] OFF_DIGITAL_PORT  = 6'h24;
  localparam logic [5:0] OFF_BOARD_CONFIG  = 6'h28;
  localparam logic [5:0] OFF_CAL_VALUES    = 6'h2C;

  localparam logic [31:0] RST_BOARD_CONTROL = 32'h0000_4060;
  localparam logic [31:0] RST_INTR_CONTROL  = 32'h0000_0008;
  localparam logic [31:0] RST_BUF_CONTROL   = 32'h0000_7FFE;
  localparam logic [31:0] RST_RATE_A        = 32'h0001_0C80;
  localparam logic [31:0] RST_RATE_B        = 32'h0000_0080;
  localparam logic [31:0] RST_SCAN_SYNC     = 32'h0000_02D1;
  localparam logic [31:0] RST_ZERO          = 32'h0000_0000;

  // writable bits of the board control register
  localparam logic [31:0] BCR_RW_MASK       = 32'h000F_BF77;
  localparam logic [31:0] SCAN_RW_MASK      = 32'h0003_FFFF;
  localparam logic [31:0] RATE_RW_MASK      = 32'h0001_FFFF;

  localparam int unsigned BIT_OUT_BURST_EN  = 9;
  localparam int unsigned BIT_OUT_SYNC      = 11;
  localparam int unsigned BIT_IN_SYNC       = 12;
  localparam int unsigned BIT_AUTOCAL       = 13;
  localparam int unsigned BIT_AUTOCAL_PASS  = 14;
  localparam int unsigned BIT_REINIT        = 15;

  localparam int unsigned SCAN_CLK_LSB      = 2;
  localparam int unsigned OUT_SYNC_LSB      = 6;
  localparam logic [1:0]  SRC_SOFTWARE      = 2'h3;

  typedef struct packed {
    logic [2:0] input_config_sel;
    logic [1:0] voltage_span;
    logic       offset_binary;
    logic       simultaneous_out;
    logic       burst_enable;
    logic       loop_enable;
    logic       term_lo_en;
    logic       term_hi_en;
    logic       current_out_en;
    logic       current_4_20;
  } board_mode_t;

  typedef struct packed {
    logic out_burst_start;
    logic in_scan_start;
    logic autocal_start;
    logic reinit_start;
  } trigger_t;

endpackage : aio_regs_pkg
`default_nettype wire

// [logic/analog_io_board_control_regs.sv]
/*
  control register bank of an analog current-loop i/o board.
  assumes the host port is synchronous to clk_sys; the engines that
  run bursts, scans, calibration and init report completion by pulses.
*/
// Behaviour
// - three-bit input mode, resets to differential
// - shared range field, resets highest range
// - bit 6 offset binary, resets high
// - bit 8 simultaneous outputs, resets low
// - bit 9 enables output burst mode
// - bit 10 enables output looping
// - bit 11 starts one burst, self clears
// - bit 12 starts one scan, self clears
// - bit 13 autocal, held until done
// - pass bit set at start, kept on success
// - bit 15 reinit loads defaults except calibration values, self clears
// - bits 16,17 input terminators per group
// - bit 18 enables current outputs
// - bit 19 selects 4-20 mA scaling
// - control register resets to 0x00004060
// - scan/sync register at 0x20, 0x2D1
// - input buffer read at 0x08 pops
// - output buffer write at 0x18 pushes
// - configuration register at 0x28 read only
// - interrupt register at 0x04, 0x08
// - scan clock code 3 selects software scan
// - burst sync code 3 selects software burst
`timescale 1ns/1ns
`default_nettype none
module analog_io_board_control_regs
  import aio_regs_pkg::*;
#(
  parameter logic [31:0] CONFIG_VALUE = 32'h0000_0001 // arbitrary value
)(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // register port
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  output logic      [31:0]       reg_rdata,
  // input sample buffer
  input  wire logic [31:0]       in_sample,
  output logic                   in_sample_pop,
  // output sample buffer
  output logic      [31:0]       out_sample,
  output logic                   out_sample_push,
  // engine completion
  input  wire logic              burst_done,
  input  wire logic              scan_done,
  input  wire logic              autocal_done,
  input  wire logic              autocal_ok,
  input  wire logic              reinit_done,
  // mode outputs
  output board_mode_t            board_mode,
  output trigger_t               trigger,
  output logic      [31:0]       scan_sync,
  output logic      [31:0]       rate_a,
  output logic      [31:0]       rate_b
);

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b01,
    CAL_RUN  = 2'b10
  } cal_state_t;

  logic [31:0] bcr_q;
  logic [31:0] intr_q;
  logic [31:0] in_ctl_q;
  logic [31:0] out_ctl_q;
  logic [31:0] rate_a_q;
  logic [31:0] rate_b_q;
  logic [31:0] scan_q;
  logic [31:0] dio_q;
  logic [31:0] cal_vals_q;
  cal_state_t  cal_q;
  logic        init_busy_q;

  function automatic logic hit(input logic [ADDR_W-1:0] off);
    hit = reg_wr && (reg_addr == off);
  endfunction : hit

  logic wr_bcr;
  logic sw_scan_src;
  logic sw_burst_src;
  logic init_load;
  assign wr_bcr       = hit(OFF_BOARD_CONTROL);
  assign sw_scan_src  = scan_q[SCAN_CLK_LSB +: 2] == SRC_SOFTWARE;
  assign sw_burst_src = scan_q[OUT_SYNC_LSB +: 2] == SRC_SOFTWARE;
  assign init_load    = init_busy_q && reinit_done;

  // board control register
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bcr_q <= RST_BOARD_CONTROL;
    end
    else if (init_load)
    begin
      bcr_q <= RST_BOARD_CONTROL;
    end
    else
    begin
      if (wr_bcr)
      begin
        bcr_q <= (bcr_q & ~BCR_RW_MASK) | (reg_wdata & BCR_RW_MASK);
        bcr_q[BIT_OUT_SYNC] <= bcr_q[BIT_OUT_SYNC] |
          (reg_wdata[BIT_OUT_SYNC] & bcr_q[BIT_OUT_BURST_EN]);
        bcr_q[BIT_IN_SYNC] <= bcr_q[BIT_IN_SYNC] | reg_wdata[BIT_IN_SYNC];
        bcr_q[BIT_AUTOCAL] <= bcr_q[BIT_AUTOCAL] | reg_wdata[BIT_AUTOCAL];
        bcr_q[BIT_REINIT]  <= bcr_q[BIT_REINIT] | reg_wdata[BIT_REINIT];
        // pass bit set at calibration start
        if (reg_wdata[BIT_AUTOCAL] && cal_q == CAL_IDLE)
        begin
          bcr_q[BIT_AUTOCAL_PASS] <= 1'b1;
        end
      end
      if (burst_done && bcr_q[BIT_OUT_SYNC])
      begin
        bcr_q[BIT_OUT_SYNC] <= 1'b0;
      end
      if (scan_done && bcr_q[BIT_IN_SYNC])
      begin
        bcr_q[BIT_IN_SYNC] <= 1'b0;
      end
      if (autocal_done && cal_q == CAL_RUN)
      begin
        bcr_q[BIT_AUTOCAL]      <= 1'b0;
        bcr_q[BIT_AUTOCAL_PASS] <= autocal_ok;
      end
    end
  end

  // calibration sequencer
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cal_q <= CAL_IDLE;
    end
    else
    begin
      case (cal_q)
        CAL_IDLE:
        begin
          if (bcr_q[BIT_AUTOCAL] && !init_busy_q)
          begin
            cal_q <= CAL_RUN;
          end
        end
        CAL_RUN:
        begin
          if (autocal_done || init_load)
          begin
            cal_q <= CAL_IDLE;
          end
        end
        default:
        begin
          cal_q <= CAL_IDLE;
        end
      endcase
    end
  end

  // board initialization in progress
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      init_busy_q <= 1'b0;
    end
    else if (init_load)
    begin
      init_busy_q <= 1'b0;
    end
    else if (wr_bcr && reg_wdata[BIT_REINIT])
    begin
      init_busy_q <= 1'b1;
    end
  end

  // remaining registers
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      intr_q     <= RST_INTR_CONTROL;
      in_ctl_q   <= RST_BUF_CONTROL;
      out_ctl_q  <= RST_BUF_CONTROL;
      rate_a_q   <= RST_RATE_A;
      rate_b_q   <= RST_RATE_B;
      scan_q     <= RST_SCAN_SYNC;
      dio_q      <= RST_ZERO;
      cal_vals_q <= RST_ZERO;
    end
    else if (init_load)
    begin
      intr_q     <= RST_INTR_CONTROL;
      in_ctl_q   <= RST_BUF_CONTROL;
      out_ctl_q  <= RST_BUF_CONTROL;
      rate_a_q   <= RST_RATE_A;
      rate_b_q   <= RST_RATE_B;
      scan_q     <= RST_SCAN_SYNC;
      dio_q      <= RST_ZERO;
    end
    else
    begin
      if (hit(OFF_INTR_CONTROL))
      begin
        intr_q <= reg_wdata;
      end
      if (hit(OFF_INPUT_BUF_CTL))
      begin
        in_ctl_q <= reg_wdata;
      end
      if (hit(OFF_OUTPUT_BUF_CT))
      begin
        out_ctl_q <= reg_wdata;
      end
      if (hit(OFF_RATE_A))
      begin
        rate_a_q <= reg_wdata & RATE_RW_MASK;
      end
      if (hit(OFF_RATE_B))
      begin
        rate_b_q <= reg_wdata & RATE_RW_MASK;
      end
      if (hit(OFF_SCAN_SYNC))
      begin
        scan_q <= reg_wdata & SCAN_RW_MASK;
      end
      if (hit(OFF_DIGITAL_PORT))
      begin
        dio_q <= reg_wdata;
      end
      if (hit(OFF_CAL_VALUES))
      begin
        cal_vals_q <= reg_wdata;
      end
    end
  end

  // read data and buffer strobes
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata       <= RST_ZERO;
      in_sample_pop   <= 1'b0;
      out_sample_push <= 1'b0;
      out_sample      <= RST_ZERO;
    end
    else
    begin
      in_sample_pop   <= reg_rd && (reg_addr == OFF_INPUT_BUF);
      out_sample_push <= hit(OFF_OUTPUT_BUF);
      if (hit(OFF_OUTPUT_BUF))
      begin
        out_sample <= reg_wdata;
      end
      if (reg_rd)
      begin
        case (reg_addr)
          OFF_BOARD_CONTROL: reg_rdata <= bcr_q;
          OFF_INTR_CONTROL:  reg_rdata <= intr_q;
          OFF_INPUT_BUF:     reg_rdata <= in_sample;
          OFF_INPUT_BUF_CTL: reg_rdata <= in_ctl_q;
          OFF_RATE_A:        reg_rdata <= rate_a_q;
          OFF_RATE_B:        reg_rdata <= rate_b_q;
          OFF_OUTPUT_BUF_CT: reg_rdata <= out_ctl_q;
          OFF_SCAN_SYNC:     reg_rdata <= scan_q;
          OFF_DIGITAL_PORT:  reg_rdata <= dio_q;
          OFF_BOARD_CONFIG:  reg_rdata <= CONFIG_VALUE;
          OFF_CAL_VALUES:    reg_rdata <= cal_vals_q;
          default:           reg_rdata <= RST_ZERO;
        endcase
      end
    end
  end

  // mode and trigger outputs
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      board_mode <= '0;
      trigger    <= '0;
      scan_sync  <= RST_SCAN_SYNC;
      rate_a     <= RST_RATE_A;
      rate_b     <= RST_RATE_B;
    end
    else
    begin
      board_mode.input_config_sel <= bcr_q[2:0];
      board_mode.voltage_span     <= bcr_q[5:4];
      board_mode.offset_binary    <= bcr_q[6];
      board_mode.simultaneous_out <= bcr_q[8];
      board_mode.burst_enable     <= bcr_q[9];
      board_mode.loop_enable      <= bcr_q[10];
      board_mode.term_lo_en       <= bcr_q[16];
      board_mode.term_hi_en       <= bcr_q[17];
      board_mode.current_out_en   <= bcr_q[18];
      board_mode.current_4_20     <= bcr_q[19];
      trigger.out_burst_start <= bcr_q[BIT_OUT_SYNC] && sw_burst_src;
      trigger.in_scan_start   <= bcr_q[BIT_IN_SYNC] && sw_scan_src;
      trigger.autocal_start   <= cal_q == CAL_RUN;
      trigger.reinit_start    <= init_busy_q;
      scan_sync <= scan_q;
      rate_a    <= rate_a_q;
      rate_b    <= rate_b_q;
    end
  end

  property p_bcr_reset;
    @(posedge clk_sys) $rose(rst_n) |-> bcr_q == RST_BOARD_CONTROL;
  endproperty
  a_bcr_reset: assert property (p_bcr_reset)
    else $error("control register not at reset value");

  property p_reinit_defaults;
    @(posedge clk_sys) disable iff (!rst_n)
      init_load |=> bcr_q == RST_BOARD_CONTROL && scan_q == RST_SCAN_SYNC;
  endproperty
  a_reinit_defaults: assert property (p_reinit_defaults)
    else $error("reinit did not load defaults");

  property p_burst_gated;
    @(posedge clk_sys) disable iff (!rst_n)
      wr_bcr && reg_wdata[BIT_OUT_SYNC] && !bcr_q[BIT_OUT_BURST_EN]
      && !bcr_q[BIT_OUT_SYNC] && !init_load |=> !bcr_q[BIT_OUT_SYNC];
  endproperty
  a_burst_gated: assert property (p_burst_gated)
    else $error("burst started while burst mode off");

  property p_scan_clear;
    @(posedge clk_sys) disable iff (!rst_n)
      scan_done && bcr_q[BIT_IN_SYNC] |=> !bcr_q[BIT_IN_SYNC];
  endproperty
  a_scan_clear: assert property (p_scan_clear)
    else $error("scan trigger not cleared");

  property p_cal_pass;
    @(posedge clk_sys) disable iff (!rst_n)
      autocal_done && cal_q == CAL_RUN && !init_load
      |=> bcr_q[BIT_AUTOCAL_PASS] == $past(autocal_ok) && !bcr_q[BIT_AUTOCAL];
  endproperty
  a_cal_pass: assert property (p_cal_pass)
    else $error("pass bit wrong after calibration");

  property p_scan_src;
    @(posedge clk_sys) disable iff (!rst_n)
      trigger.in_scan_start |-> $past(sw_scan_src) && $past(bcr_q[BIT_IN_SYNC]);
  endproperty
  a_scan_src: assert property (p_scan_src)
    else $error("scan trigger without software source");

  property p_pop;
    @(posedge clk_sys) disable iff (!rst_n)
      reg_rd && reg_addr == OFF_INPUT_BUF |=> in_sample_pop;
  endproperty
  a_pop: assert property (p_pop)
    else $error("input buffer read did not pop");

  property p_reserved_zero;
    @(posedge clk_sys) disable iff (!rst_n)
      bcr_q[31:20] == 12'h000 && !bcr_q[3] && !bcr_q[7]
      && scan_q[31:18] == 14'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bit set");

endmodule : analog_io_board_control_regs
`default_nettype wire

// [testbench/test_analog_io_board_control_regs.sv]
/*
  self-checking bench for the board control register bank.
  assumes one-cycle strobes and completion pulses driven at negedge.
*/
`timescale 1ns/1ns
`default_nettype none
module test_analog_io_board_control_regs
  import aio_regs_pkg::*;
;
  localparam logic [31:0] CFG = 32'h0000_0A5C; // arbitrary value
  localparam logic [5:0]  RA [0:9] = '{6'h00, 6'h04, 6'h0C, 6'h10, 6'h14,
    6'h1C, 6'h20, 6'h30, 6'h18, 6'h3C};
  localparam logic [31:0] RV [0:9] = '{32'h0000_4060, 32'h0000_0008,
    32'h0000_7FFE, 32'h0001_0C80, 32'h0000_0080, 32'h0000_7FFE,
    32'h0000_02D1, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
  // control writes and the mode word each should give
  localparam logic [31:0] FW [0:4] = '{32'h0000_0035, 32'h0001_0040,
    32'h0002_0100, 32'h000C_0600, 32'h0000_0010};
  localparam logic [31:0] FM [0:4] = '{32'h0000_1700, 32'h0000_0088,
    32'h0000_0044, 32'h0000_0033, 32'h0000_0100};

  logic              clk_sys;
  logic              rst_n;
  logic              reg_wr;
  logic              reg_rd;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0]       reg_wdata;
  logic [31:0]       reg_rdata;
  logic [31:0]       in_sample;
  logic              in_sample_pop;
  logic [31:0]       out_sample;
  logic              out_sample_push;
  logic [3:0]        done_v;
  logic              autocal_ok;
  board_mode_t       board_mode;
  trigger_t          trigger;
  logic [31:0]       scan_sync;
  logic [31:0]       rate_a;
  logic [31:0]       rate_b;
  logic              pop_seen;
  logic              push_seen;
  int                fails;
  int                compares;
  int                cycles;

  analog_io_board_control_regs #(
    .CONFIG_VALUE (CFG)
  ) dut (
    .clk_sys         (clk_sys),
    .rst_n           (rst_n),
    .reg_wr          (reg_wr),
    .reg_rd          (reg_rd),
    .reg_addr        (reg_addr),
    .reg_wdata       (reg_wdata),
    .reg_rdata       (reg_rdata),
    .in_sample       (in_sample),
    .in_sample_pop   (in_sample_pop),
    .out_sample      (out_sample),
    .out_sample_push (out_sample_push),
    .burst_done      (done_v[0]),
    .scan_done       (done_v[1]),
    .autocal_done    (done_v[2]),
    .autocal_ok      (autocal_ok),
    .reinit_done     (done_v[3]),
    .board_mode      (board_mode),
    .trigger         (trigger),
    .scan_sync       (scan_sync),
    .rate_a          (rate_a),
    .rate_b          (rate_b)
  );

  task automatic final_report;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick

  // strobe for one edge, then leave one idle edge
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    tick(1);
    reg_wr    = 1'b0;
    push_seen = out_sample_push;
    tick(1);
  endtask : wr

  task automatic rdc(input string what, input logic [5:0] a,
                     input logic [31:0] exp);
    reg_rd   = 1'b1;
    reg_addr = a;
    tick(1);
    reg_rd   = 1'b0;
    pop_seen = in_sample_pop;
    check(what, reg_rdata, exp);
    tick(1);
  endtask : rdc

  task automatic pulse(input logic [3:0] v);
    done_v = v;
    tick(1);
    done_v = 4'h0;
    tick(1);
  endtask : pulse

  task automatic t_reset;
    for (int i = 0; i < 10; i++)
      rdc("reset value", RA[i], RV[i]);
    check("mode reset", {19'h0, board_mode}, 32'h0000_0280);
    check("rate_a reset", rate_a, 32'h0001_0C80);
    check("scan reset", scan_sync, 32'h0000_02D1);
  endtask : t_reset

  task automatic t_fields;
    wr(OFF_BOARD_CONTROL, 32'hFFFF_07FF);
    tick(2);
    rdc("bcr all ones", OFF_BOARD_CONTROL, 32'h000F_4777);
    check("mode all", {19'h0, board_mode}, 32'h0000_1FFF);
    for (int i = 0; i < 5; i++)
    begin
      wr(OFF_BOARD_CONTROL, FW[i]);
      tick(2);
      rdc("bcr field", OFF_BOARD_CONTROL, FW[i] | 32'h0000_4000);
      check("mode field", {19'h0, board_mode}, FM[i]);
    end
  endtask : t_fields

  task automatic t_burst;
    wr(OFF_BOARD_CONTROL, 32'h0000_0800);
    rdc("sync no burst", OFF_BOARD_CONTROL, 32'h0000_4000);
    wr(OFF_BOARD_CONTROL, 32'h0000_0200);
    wr(OFF_BOARD_CONTROL, 32'h0000_0A00);
    wr(OFF_BOARD_CONTROL, 32'h0000_0200);
    rdc("sync held", OFF_BOARD_CONTROL, 32'h0000_4A00);
    check("burst trig", {28'h0, trigger}, 32'h0000_0008);
    pulse(4'b0001);
    rdc("sync cleared", OFF_BOARD_CONTROL, 32'h0000_4200);
    check("burst trig off", {28'h0, trigger}, 32'h0000_0000);
    wr(OFF_SCAN_SYNC, 32'h0000_0291);
    wr(OFF_BOARD_CONTROL, 32'h0000_0A00);
    tick(2);
    check("burst other src", {28'h0, trigger}, 32'h0000_0000);
    pulse(4'b0001);
  endtask : t_burst

  task automatic t_scan;
    wr(OFF_BOARD_CONTROL, 32'h0000_1000);
    rdc("scan bit", OFF_BOARD_CONTROL, 32'h0000_5000);
    check("scan other src", {28'h0, trigger}, 32'h0000_0000);
    wr(OFF_SCAN_SYNC, 32'hFFFC_02DD);
    tick(2);
    rdc("scan masked", OFF_SCAN_SYNC, 32'h0000_02DD);
    check("scan out", scan_sync, 32'h0000_02DD);
    check("scan trig", {28'h0, trigger}, 32'h0000_0004);
    pulse(4'b0010);
    rdc("scan cleared", OFF_BOARD_CONTROL, 32'h0000_4000);
  endtask : t_scan

  task automatic t_autocal(input logic ok);
    autocal_ok = ok;
    wr(OFF_BOARD_CONTROL, 32'h0000_2000);
    tick(2);
    rdc("cal running", OFF_BOARD_CONTROL, 32'h0000_6000);
    check("cal trig", {28'h0, trigger}, 32'h0000_0002);
    pulse(4'b0100);
    rdc("cal result", OFF_BOARD_CONTROL, {17'h0, ok, 14'h0});
    check("cal trig off", {28'h0, trigger}, 32'h0000_0000);
  endtask : t_autocal

  task automatic t_bufs;
    in_sample = 32'h0001_ABCD;
    rdc("input sample", OFF_INPUT_BUF, 32'h0001_ABCD);
    check("pop", {31'h0, pop_seen}, 32'h0000_0001);
    wr(OFF_OUTPUT_BUF, 32'h0000_1234);
    check("push", {31'h0, push_seen}, 32'h0000_0001);
    check("out sample", out_sample, 32'h0000_1234);
    rdc("output buf read", OFF_OUTPUT_BUF, 32'h0000_0000);
    wr(OFF_BOARD_CONFIG, 32'hFFFF_FFFF);
    rdc("config", OFF_BOARD_CONFIG, CFG);
    wr(OFF_INTR_CONTROL, 32'h0000_0005);
    rdc("intr", OFF_INTR_CONTROL, 32'h0000_0005);
    wr(OFF_RATE_A, 32'hFFFF_FFFF);
    rdc("rate_a mask", OFF_RATE_A, 32'h0001_FFFF);
    check("rate_a out", rate_a, 32'h0001_FFFF);
    wr(OFF_RATE_B, 32'hFFFF_FFFF);
    rdc("rate_b mask", OFF_RATE_B, 32'h0001_FFFF);
    check("rate_b out", rate_b, 32'h0001_FFFF);
    wr(OFF_DIGITAL_PORT, 32'h0000_5A5A);
    rdc("dio", OFF_DIGITAL_PORT, 32'h0000_5A5A);
    wr(OFF_INPUT_BUF_CTL, 32'h0000_1234);
    rdc("in ctl", OFF_INPUT_BUF_CTL, 32'h0000_1234);
    wr(OFF_OUTPUT_BUF_CT, 32'h0000_0ABC);
    rdc("out ctl", OFF_OUTPUT_BUF_CT, 32'h0000_0ABC);
    wr(OFF_CAL_VALUES, 32'h1234_5678);
    wr(6'h30, 32'hFFFF_FFFF);
    rdc("reserved", 6'h30, 32'h0000_0000);
  endtask : t_bufs

  task automatic t_reinit;
    wr(OFF_BOARD_CONTROL, 32'h0000_8035);
    tick(2);
    rdc("init busy", OFF_BOARD_CONTROL, 32'h0000_C035);
    check("init trig", {28'h0, trigger}, 32'h0000_0001);
    pulse(4'b1000);
    tick(2);
    rdc("init bcr", OFF_BOARD_CONTROL, 32'h0000_4060);
    rdc("init rate_a", OFF_RATE_A, 32'h0001_0C80);
    rdc("init rate_b", OFF_RATE_B, 32'h0000_0080);
    rdc("init dio", OFF_DIGITAL_PORT, 32'h0000_0000);
    rdc("init in ctl", OFF_INPUT_BUF_CTL, 32'h0000_7FFE);
    rdc("init out ctl", OFF_OUTPUT_BUF_CT, 32'h0000_7FFE);
    rdc("init intr", OFF_INTR_CONTROL, 32'h0000_0008);
    rdc("init scan", OFF_SCAN_SYNC, 32'h0000_02D1);
    rdc("cal kept", OFF_CAL_VALUES, 32'h1234_5678);
    check("init mode", {19'h0, board_mode}, 32'h0000_0280);
    check("init rate_b out", rate_b, 32'h0000_0080);
    check("init trig off", {28'h0, trigger}, 32'h0000_0000);
  endtask : t_reinit

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      final_report();
    end
  end

  initial
  begin
    fails      = 0;
    compares   = 0;
    cycles     = 0;
    rst_n      = 1'b0;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    reg_addr   = 6'h00;
    reg_wdata  = 32'h0000_0000;
    in_sample  = 32'h0000_0000;
    done_v     = 4'h0;
    autocal_ok = 1'b0;
    tick(5);
    rst_n = 1'b1;
    tick(2);
    t_reset();
    t_fields();
    t_burst();
    t_scan();
    t_autocal(1'b0);
    t_autocal(1'b1);
    t_bufs();
    t_reinit();
    final_report();
  end
endmodule : test_analog_io_board_control_regs
`default_nettype wire
